// File: bench/ctrl_model.sv
// Controller-side model: link clock, command pins and write strobe
module ctrl_model
  import spacing_pkg::*;
(
  input wire logic clk,
  input wire logic dev_dqs,
  input wire logic dev_oe_n,
  output logic ck,
  output logic [2:0] cmd,
  output logic [2:0] bank,
  output logic [7:0] mode,
  output logic dqs,
  output logic dqs_drv
);
  timeunit 1ns;
  timeprecision 1ps;

  logic val_r = 1'b0;
  logic alt_r = 1'b0;

  // Pins idle at time zero, strobe not driven
  initial
  begin
    cmd = CMD_NOP;
    bank = 3'h0;
    mode = 8'h00;
    dqs_drv = 1'b0;
  end

  // Free-running link clock, phase unrelated to the own clock
  initial
  begin
    ck = 1'b0;
    #37;
    forever #100 ck = ~ck;
  end

  // Released wire shows a changing pattern, never a held level
  always @(negedge clk) alt_r <= ~alt_r;
  assign dqs = dqs_drv ? val_r : (!dev_oe_n ? dev_dqs : alt_r);

  // One link cycle of command; changed while link clock is low
  task automatic cyc(input cmd_t c, input logic [2:0] b,
    input logic [7:0] m);
    @(negedge ck);
    @(negedge clk);
    cmd = c;
    bank = b;
    mode = m;
  endtask

  // Write burst framing; lengths in own-clock cycles
  task automatic wstrobe(input int pre, input int post);
    dqs_drv = 1'b1;
    val_r = 1'b0;
    repeat (pre) @(negedge clk);
    // Last fall opens the postamble, so no trailing low half here
    repeat (3)
    begin
      val_r = 1'b1;
      repeat (4) @(negedge clk);
      val_r = 1'b0;
      repeat (4) @(negedge clk);
    end
    val_r = 1'b1;
    repeat (4) @(negedge clk);
    val_r = 1'b0;
    repeat (post) @(negedge clk);
    dqs_drv = 1'b0;
  endtask
endmodule

// File: bench/tb_ddr3_command_spacing_checker.sv
// Self-checking bench of the command spacing checker
module tb_ddr3_command_spacing_checker
  import spacing_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic CLK, RST_N, CK, GRADE_FAST, BURST_LENGTH_8, DQS_IN, DQS_DRIVEN;
  logic VIOL_CLR, DQS_OUT, DQS_OE_N;
  logic [2:0] CMD, BANK;
  logic [7:0] MODE_IN, MODE_SETTING, pend, v, pv;
  logic [4:0] READ_LATENCY;
  logic [NUM_VIOL-1:0] VIOLATION, ev;
  int err_count, comparisons, n, e, g, i, k, rl, half;
  int t_rd, b_rd, t_wr, t_wra, b_wra, t_mrs, t_col, t_mpr, t_act, b_act;
  cmd_t fa [8] = '{CMD_RD, CMD_WR, CMD_WRA, CMD_MRS, CMD_MRS, CMD_WR,
    CMD_MPR_EXIT, CMD_ACT};
  cmd_t sa [8] = '{CMD_PRE, CMD_RD, CMD_ACT, CMD_MRS, CMD_WR, CMD_WR,
    CMD_ACT, CMD_ACT};
  int na [8] = '{4, 4, 2, 4, 12, 4, 2, 4};

  ddr3_command_spacing_checker uut (.CLK(CLK), .RST_N(RST_N), .CE(1'b1),
    .CK(CK), .CMD(CMD), .BANK(BANK), .MODE_IN(MODE_IN),
    .GRADE_FAST(GRADE_FAST), .READ_LATENCY(READ_LATENCY),
    .BURST_LENGTH_8(BURST_LENGTH_8), .DQS_IN(DQS_IN),
    .DQS_DRIVEN(DQS_DRIVEN), .VIOL_CLR(VIOL_CLR),
    .MODE_SETTING(MODE_SETTING), .DQS_OUT(DQS_OUT), .DQS_OE_N(DQS_OE_N),
    .VIOLATION(VIOLATION));

  ctrl_model pm (.clk(CLK), .dev_dqs(DQS_OUT), .dev_oe_n(DQS_OE_N),
    .ck(CK), .cmd(CMD), .bank(BANK), .mode(MODE_IN), .dqs(DQS_IN),
    .dqs_drv(DQS_DRIVEN));

  // Own clock, 25 ns
  initial
  begin
    CLK = 1'b0;
    forever #12.5 CLK = ~CLK;
  end

  task automatic chk(input logic [15:0] s, input logic [15:0] x);
    comparisons++;
    if (s !== x)
    begin
      err_count++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, s, x);
    end
  endtask

  task automatic end_of_test;
    $display("Comparisons %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // One link cycle; the model flags gaps shorter than the minimum
  task automatic send(input cmd_t c, input logic [2:0] b,
    input logic [7:0] m);
    pm.cyc(c, b, m);
    n++;
    if (c != CMD_NOP && n - t_mpr < 2) ev[6] = 1'b1;
    if (c != CMD_NOP && c != CMD_MRS && n - t_mrs < 12)
      ev[4] = 1'b1;
    if (c inside {CMD_RD, CMD_WR, CMD_WRA})
    begin
      if (n - t_col < 4) ev[5] = 1'b1;
      t_col = n;
    end
    case (c)
      CMD_PRE: if (b == b_rd && n - t_rd < 4) ev[0] = 1'b1;
      CMD_RD:
      begin
        if (n - t_wr < 4) ev[1] = 1'b1;
        t_rd = n;
        b_rd = b;
      end
      CMD_WR: t_wr = n;
      CMD_WRA:
      begin
        t_wr = n;
        t_wra = n;
        b_wra = b;
      end
      CMD_ACT:
      begin
        if (b == b_wra && n - t_wra < 2) ev[2] = 1'b1;
        if (b != b_act && n - t_act < 4) ev[7] = 1'b1;
        t_act = n;
        b_act = b;
      end
      CMD_MRS:
      begin
        if (n - t_mrs < 4) ev[3] = 1'b1;
        t_mrs = n;
        pend = m;
      end
      CMD_MPR_EXIT: t_mpr = n;
      default: ;
    endcase
  endtask

  // Idle long enough for every gap and mode update, compare, clear
  task automatic flush_check;
    repeat (14) send(CMD_NOP, 3'h0, 8'h00);
    repeat (2) @(negedge CLK);
    chk(16'(VIOLATION), 16'(ev));
    chk(16'(MODE_SETTING), 16'(pend));
    VIOL_CLR = 1'b1;
    @(negedge CLK);
    VIOL_CLR = 1'b0;
    ev = '0;
  endtask

  // Cut a hang short
  initial
  begin
    #1ms;
    err_count++;
    $display("CHECK FAILED at %0t: run time limit", $time);
    end_of_test();
  end

  initial
  begin
    {RST_N, GRADE_FAST, BURST_LENGTH_8, VIOL_CLR} = 4'h0;
    READ_LATENCY = 5'h05;
    {err_count, comparisons, n} = 0;
    {t_rd, t_wr, t_wra, t_mrs, t_col, t_mpr, t_act} = {7{-100}};
    {b_rd, b_wra, b_act} = 0;
    ev = '0;
    pend = MODE_RESET;
    void'($urandom(52571));
    repeat (5) @(negedge CLK);
    RST_N = 1'b1;
    chk(16'(MODE_SETTING), 16'h0000);
    chk(16'(DQS_OE_N), 16'h0001);
    // Each minimum gap one short, then exactly met
    for (e = 0; e < 8; e++)
      for (g = na[e] - 1; g <= na[e]; g++)
      begin
        GRADE_FAST = 1'($urandom % 2);
        send(fa[e], 3'h0, 8'($urandom));
        repeat (g - 1) send(CMD_NOP, 3'h0, 8'h00);
        send(sa[e], 3'(e == 7), 8'($urandom));
        flush_check();
      end
    $display("test gap table done");
    // Mode value held back until the twelfth link cycle
    pv = pend;
    v = pv + 8'(1 + $urandom % 255);
    send(CMD_MRS, 3'h0, v);
    repeat (12) send(CMD_NOP, 3'h0, 8'h00);
    repeat (2) @(negedge CLK);
    chk(16'(MODE_SETTING), 16'(pv));
    send(CMD_NOP, 3'h0, 8'h00);
    repeat (2) @(negedge CLK);
    chk(16'(MODE_SETTING), 16'(v));
    flush_check();
    $display("test mode update done");
    // Random command mix with random spacing
    repeat (60)
    begin
      send(cmd_t'(3'($urandom % 8)), 3'($urandom % 2), 8'($urandom));
      repeat ($urandom % 4) send(CMD_NOP, 3'h0, 8'h00);
    end
    flush_check();
    $display("test random mix done");
    // Read strobe window against latency and burst length
    for (i = 0; i < 4; i++)
    begin
      rl = 2 + $urandom % 6;
      BURST_LENGTH_8 = 1'(i % 2);
      half = BURST_LENGTH_8 ? 4 : 2;
      READ_LATENCY = 5'(rl);
      send(CMD_RD, 3'h0, 8'h00);
      for (k = 1; k <= rl + half + 2; k++)
      begin
        send(CMD_NOP, 3'h0, 8'h00);
        repeat (2) @(negedge CLK);
        chk(16'(DQS_OE_N), 16'(!(k >= rl && k <= rl + half)));
        if (k == rl) chk(16'(DQS_OUT), 16'h0000);
        // Wait past the link rise so the burst strobe shows high
        if (k == rl + 1)
        begin
          repeat (4) @(negedge CLK);
          chk(16'(DQS_OUT), 16'h0001);
        end
      end
      flush_check();
    end
    $display("test read strobe done");
    // Write preamble and postamble, short and long
    for (i = 0; i < 4; i++)
    begin
      pm.wstrobe((i % 2) ? 9 : 6, (i > 1) ? 5 : 2);
      ev[8] = !(i % 2);
      ev[9] = !(i > 1);
      repeat (6) @(negedge CLK);
      flush_check();
    end
    $display("test write strobe done");
    end_of_test();
  end
endmodule

// File: design/ddr3_command_spacing_checker.sv
// Device-side command spacing checker, mode update and strobe framing
module ddr3_command_spacing_checker
  import spacing_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic CE,
  input wire logic CK,
  input wire logic [2:0] CMD,
  input wire logic [2:0] BANK,
  input wire logic [7:0] MODE_IN,
  input wire logic GRADE_FAST,
  input wire logic [4:0] READ_LATENCY,
  input wire logic BURST_LENGTH_8,
  input wire logic DQS_IN,
  input wire logic DQS_DRIVEN,
  input wire logic VIOL_CLR,
  output logic [7:0] MODE_SETTING,
  output logic DQS_OUT,
  output logic DQS_OE_N,
  output logic [NUM_VIOL-1:0] VIOLATION
);

  // Pin synchronisers; the link clock is a sampled input here
  logic [16:0] pin_s1_r;
  logic [16:0] pin_s2_r;
  logic ck_d_r;
  logic dqs_d_r;

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
    end
    else if (CE)
    begin
      pin_s1_r <= {CK, CMD, BANK, MODE_IN, DQS_IN, DQS_DRIVEN};
      pin_s2_r <= pin_s1_r;
    end
  end

  logic ck_s;
  logic [2:0] bank_s;
  logic [7:0] mode_s;
  logic dqs_s;
  logic drv_s;
  cmd_t cmd_s;
  logic tick;

  assign ck_s = pin_s2_r[16];
  assign cmd_s = cmd_t'(pin_s2_r[15:13]);
  assign bank_s = pin_s2_r[12:10];
  assign mode_s = pin_s2_r[9:2];
  assign dqs_s = pin_s2_r[1];
  assign drv_s = pin_s2_r[0];

  // Edge detectors read only the second stage
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      ck_d_r <= 1'b0;
      dqs_d_r <= 1'b0;
    end
    else if (CE)
    begin
      ck_d_r <= ck_s;
      dqs_d_r <= dqs_s;
    end
  end

  // Commands are taken on each rising link clock edge
  assign tick = CE && ck_s && !ck_d_r;

  logic is_col;
  logic is_any;
  assign is_col = (cmd_s == CMD_RD) || (cmd_s == CMD_WR) || (cmd_s == CMD_WRA);
  assign is_any = (cmd_s != CMD_NOP);

  // Banks remembered for bank-qualified gaps
  logic [2:0] rd_bank_r;
  logic [2:0] wra_bank_r;
  logic [2:0] act_bank_r;

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      rd_bank_r <= 3'h0;
      wra_bank_r <= 3'h0;
      act_bank_r <= 3'h0;
    end
    else if (tick)
    begin
      if (cmd_s == CMD_RD)
        rd_bank_r <= bank_s;
      if (cmd_s == CMD_WRA)
        wra_bank_r <= bank_s;
      if (cmd_s == CMD_ACT)
        act_bank_r <= bank_s;
    end
  end

  // One gap counter per spacing check
  gap_if g [NUM_GAPS] ();

  genvar gi;
  generate
    for (gi = 0; gi < NUM_GAPS; gi++)
    begin : gap_gen
      assign g[gi].tick = tick;
      spacing_counter u_cnt (
        .clk(CLK),
        .rst_n(RST_N),
        .ce(CE),
        .port(g[gi])
      );
    end
  endgenerate

  // Opening command, checked command and gap for each counter
  assign g[V_RD_PRE].start = (cmd_s == CMD_RD);
  assign g[V_RD_PRE].check = (cmd_s == CMD_PRE) && (bank_s == rd_bank_r);
  assign g[V_RD_PRE].gap = CNT_W'(READ_TO_PRECHARGE_GAP);
  assign g[V_WR_RD].start = (cmd_s == CMD_WR) || (cmd_s == CMD_WRA);
  assign g[V_WR_RD].check = (cmd_s == CMD_RD);
  assign g[V_WR_RD].gap = CNT_W'(STORE_TO_READ_GAP);
  assign g[V_AUTOCLOSE].start = (cmd_s == CMD_WRA);
  assign g[V_AUTOCLOSE].check = (cmd_s == CMD_ACT) && (bank_s == wra_bank_r);
  assign g[V_AUTOCLOSE].gap = CNT_W'(AUTOCLOSE_STORE_TOTAL);
  assign g[V_MRS_MRS].start = (cmd_s == CMD_MRS);
  assign g[V_MRS_MRS].check = (cmd_s == CMD_MRS);
  assign g[V_MRS_MRS].gap = CNT_W'(MODE_SET_SPACING);
  assign g[V_MRS_ANY].start = (cmd_s == CMD_MRS);
  assign g[V_MRS_ANY].check = is_any && (cmd_s != CMD_MRS);
  assign g[V_MRS_ANY].gap = CNT_W'(MODE_SET_UPDATE_DELAY);
  assign g[V_COLUMN].start = is_col;
  assign g[V_COLUMN].check = is_col;
  assign g[V_COLUMN].gap = CNT_W'(COLUMN_COMMAND_SPACING);
  assign g[V_MPR].start = (cmd_s == CMD_MPR_EXIT);
  assign g[V_MPR].check = is_any;
  assign g[V_MPR].gap = CNT_W'(PURPOSE_REG_RECOVERY + 1);
  assign g[V_ACT].start = (cmd_s == CMD_ACT);
  assign g[V_ACT].check = (cmd_s == CMD_ACT) && (bank_s != act_bank_r);
  assign g[V_ACT].gap = GRADE_FAST ? CNT_W'(ACTIVATE_SPACING_FAST)
                                   : CNT_W'(ACTIVATE_SPACING_SLOW);

  // Mode setting is held pending until the update delay has run out
  logic [7:0] mode_pending_r;
  logic [7:0] mode_r;

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      mode_pending_r <= MODE_RESET;
      mode_r <= MODE_RESET;
    end
    else if (CE)
    begin
      if (tick && cmd_s == CMD_MRS)
        mode_pending_r <= mode_s;
      if (g[V_MRS_ANY].done)
        mode_r <= mode_pending_r;
    end
  end

  assign MODE_SETTING = mode_r;

  // Read strobe window; a new read restarts it, so bursts do not overlap
  logic rd_active_r;
  logic [AGE_W-1:0] rd_age_r;
  logic [AGE_W-1:0] lat_age;
  logic [AGE_W-1:0] start_age;
  logic [AGE_W-1:0] end_age;

  assign lat_age = {1'b0, READ_LATENCY};
  assign start_age = lat_age - STROBE_DRIVE_START;
  assign end_age = lat_age + (BURST_LENGTH_8 ? BURST_HALF_8 : BURST_HALF_4);

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      rd_active_r <= 1'b0;
      rd_age_r <= '0;
    end
    else if (tick)
    begin
      if (cmd_s == CMD_RD)
      begin
        rd_active_r <= 1'b1;
        rd_age_r <= '0;
      end
      else if (rd_active_r)
      begin
        rd_age_r <= rd_age_r + 6'h01;
        if (rd_age_r + 6'h01 == end_age)
          rd_active_r <= 1'b0;
      end
    end
  end

  // Strobe pins registered; low preamble until latency, then follow link
  logic dqs_oe_n_r;
  logic dqs_out_r;

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      dqs_oe_n_r <= 1'b1;
      dqs_out_r <= 1'b0;
    end
    else if (CE)
    begin
      dqs_oe_n_r <= !(rd_active_r && rd_age_r >= start_age);
      dqs_out_r <= rd_active_r && (rd_age_r >= lat_age) && ck_s;
    end
  end

  assign DQS_OE_N = dqs_oe_n_r;
  assign DQS_OUT = dqs_out_r;

  // Write strobe framing measured at the own clock rate
  wr_state_t wr_state_r;
  logic [STB_W-1:0] stb_cnt_r;
  logic pre_short;
  logic post_short;
  logic dqs_rise;
  logic dqs_fall;

  assign dqs_rise = dqs_s && !dqs_d_r;
  assign dqs_fall = !dqs_s && dqs_d_r;
  assign pre_short = CE && (wr_state_r == WS_PRE) && drv_s && dqs_rise
    && (stb_cnt_r < STB_W'(PREAMBLE_CLK));
  assign post_short = CE && (wr_state_r == WS_BURST) && !drv_s
    && (stb_cnt_r < STB_W'(POSTAMBLE_CLK));

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      wr_state_r <= WS_IDLE;
      stb_cnt_r <= '0;
    end
    else if (CE)
    begin
      unique case (wr_state_r)
        WS_IDLE:
        begin
          stb_cnt_r <= 4'h1;
          if (drv_s)
            wr_state_r <= WS_PRE;
        end
        WS_PRE:
        begin
          if (!drv_s)
            wr_state_r <= WS_IDLE;
          else if (dqs_rise)
          begin
            wr_state_r <= WS_BURST;
            stb_cnt_r <= '0;
          end
          else if (stb_cnt_r != 4'hF)
            stb_cnt_r <= stb_cnt_r + 4'h1;
        end
        WS_BURST:
        begin
          if (!drv_s)
            wr_state_r <= WS_IDLE;
          else if (dqs_fall)
            stb_cnt_r <= 4'h1;
          else if (stb_cnt_r != 4'hF)
            stb_cnt_r <= stb_cnt_r + 4'h1;
        end
        default:
          wr_state_r <= WS_IDLE;
      endcase
    end
  end

  // Sticky violation flags; a new violation beats a clear
  logic [NUM_VIOL-1:0] viol_set;
  logic [NUM_VIOL-1:0] viol_r;

  always_comb
  begin
    viol_set = '0;
    viol_set[V_RD_PRE] = g[V_RD_PRE].viol;
    viol_set[V_WR_RD] = g[V_WR_RD].viol;
    viol_set[V_AUTOCLOSE] = g[V_AUTOCLOSE].viol;
    viol_set[V_MRS_MRS] = g[V_MRS_MRS].viol;
    viol_set[V_MRS_ANY] = g[V_MRS_ANY].viol;
    viol_set[V_COLUMN] = g[V_COLUMN].viol;
    viol_set[V_MPR] = g[V_MPR].viol;
    viol_set[V_ACT] = g[V_ACT].viol;
    viol_set[V_PREAMBLE] = pre_short;
    viol_set[V_POSTAMBLE] = post_short;
  end

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
      viol_r <= '0;
    else if (CE)
      viol_r <= (viol_r & ~{NUM_VIOL{VIOL_CLR}}) | viol_set;
  end

  assign VIOLATION = viol_r;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  sequence mrs_taken;
    tick && cmd_s == CMD_MRS;
  endsequence

  // An older update may land on the very tick of a new mode set
  mode_hold_a: assert property (mrs_taken ##0 !g[V_MRS_ANY].done |=>
    $stable(mode_r) [*8])
    else $error("mode setting changed too soon after mode set");
  mode_cause_a: assert property ($changed(mode_r) |->
    $past(g[V_MRS_ANY].done))
    else $error("mode setting changed without update delay");
  strobe_start_a: assert property ($fell(dqs_oe_n_r) |->
    $past(rd_active_r && rd_age_r == start_age))
    else $error("read strobe driven at wrong link cycle");
  strobe_release_a: assert property ($rose(dqs_oe_n_r) |->
    $past(!rd_active_r && rd_age_r == end_age)
    || $past(tick && cmd_s == CMD_RD, 2))
    else $error("read strobe released at wrong link cycle");
  strobe_quiet_a: assert property (dqs_oe_n_r |-> !dqs_out_r)
    else $error("strobe high while released");
  dal_flag_a: assert property (g[V_AUTOCLOSE].viol |=>
    viol_r[V_AUTOCLOSE])
    else $error("auto close gap breach not flagged");
  preamble_flag_a: assert property (pre_short |=> viol_r[V_PREAMBLE])
    else $error("short write preamble not flagged");
  viol_sticky_a: assert property (CE && !VIOL_CLR |=>
    (($past(viol_r) & ~viol_r) == '0))
    else $error("violation flag lost without clear");

endmodule

// File: design/gap_if.sv
// Handshake between the command decoder and one spacing counter
interface gap_if;
  import spacing_pkg::*;
  logic tick;
  logic start;
  logic check;
  logic [CNT_W-1:0] gap;
  logic viol;
  logic done;
  modport sub (input tick, input start, input check, input gap,
    output viol, output done);
  modport user (output tick, output start, output check, output gap,
    input viol, input done);
endinterface

// File: design/spacing_counter.sv
// One command-to-command gap counter, counted in link cycles
module spacing_counter
  import spacing_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  gap_if.sub port
);

  logic [CNT_W-1:0] remain_r;

  // Load on the opening command, count down on each link cycle
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      remain_r <= '0;
    else if (ce && port.tick)
    begin
      if (port.start)
        remain_r <= port.gap;
      else if (remain_r != 5'h00)
        remain_r <= remain_r - 5'h01;
    end
  end

  // A gap of N is met once N link cycles have passed since the start
  assign port.viol = ce && port.tick && port.check && (remain_r > 5'h01);
  assign port.done = ce && port.tick && (remain_r == 5'h01);

endmodule

// File: design/spacing_pkg.sv
// Shared constants, command codes and state types of the spacing checker
package spacing_pkg;

  // Clock rates: own clock and the sampled link clock
  localparam int CLK_PERIOD_PS = 25000;
  localparam int LINK_PERIOD_PS = 200000;
  localparam int CNT_W = 5;
  localparam int AGE_W = 6;
  localparam int STB_W = 4;

  // Picosecond limit rounded up to link cycles, then floored by a count
  function automatic int to_cyc(input int ps, input int floor_cyc);
    int c;
    c = (ps + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS;
    return (c > floor_cyc) ? c : floor_cyc;
  endfunction

  // Times in picoseconds, as printed
  localparam int READ_TO_PRECHARGE_PS = 7500;
  localparam int STORE_TO_READ_PS = 7500;
  localparam int STORE_RECOVERY_TIME_PS = 15000;
  localparam int PRECHARGE_PERIOD_PS = 13910;
  localparam int MODE_SET_UPDATE_PS = 15000;
  localparam int ACTIVATE_FAST_PS = 6000;
  localparam int ACTIVATE_SLOW_PS = 7500;

  // Gaps in link cycles
  localparam int READ_TO_PRECHARGE_GAP = to_cyc(READ_TO_PRECHARGE_PS, 4);
  localparam int STORE_TO_READ_GAP = to_cyc(STORE_TO_READ_PS, 4);
  localparam int AUTOCLOSE_STORE_TOTAL =
    to_cyc(STORE_RECOVERY_TIME_PS, 1) + to_cyc(PRECHARGE_PERIOD_PS, 1);
  localparam int MODE_SET_SPACING = 4;
  localparam int MODE_SET_UPDATE_DELAY = to_cyc(MODE_SET_UPDATE_PS, 12);
  localparam int COLUMN_COMMAND_SPACING = 4;
  localparam int PURPOSE_REG_RECOVERY = 1;
  localparam int ACTIVATE_SPACING_FAST = to_cyc(ACTIVATE_FAST_PS, 4);
  localparam int ACTIVATE_SPACING_SLOW = to_cyc(ACTIVATE_SLOW_PS, 4);

  // Write strobe framing, in thousandths of a link period, then rounded up to own-clock cycles
  localparam int STORE_STROBE_PREAMBLE_PM = 900;
  localparam int STORE_STROBE_POSTAMBLE_PM = 300;
  localparam int PREAMBLE_CLK = (STORE_STROBE_PREAMBLE_PM * LINK_PERIOD_PS
    + 1000 * CLK_PERIOD_PS - 1) / (1000 * CLK_PERIOD_PS);
  localparam int POSTAMBLE_CLK = (STORE_STROBE_POSTAMBLE_PM * LINK_PERIOD_PS
    + 1000 * CLK_PERIOD_PS - 1) / (1000 * CLK_PERIOD_PS);

  // Read strobe window, in link cycles
  localparam logic [AGE_W-1:0] STROBE_DRIVE_START = 6'h01;
  localparam logic [AGE_W-1:0] BURST_HALF_8 = 6'h04;
  localparam logic [AGE_W-1:0] BURST_HALF_4 = 6'h02;

  // Reset values
  localparam logic [7:0] MODE_RESET = 8'h00;

  // Violation flag positions
  localparam int NUM_VIOL = 10;
  localparam int V_RD_PRE = 0;
  localparam int V_WR_RD = 1;
  localparam int V_AUTOCLOSE = 2;
  localparam int V_MRS_MRS = 3;
  localparam int V_MRS_ANY = 4;
  localparam int V_COLUMN = 5;
  localparam int V_MPR = 6;
  localparam int V_ACT = 7;
  localparam int V_PREAMBLE = 8;
  localparam int V_POSTAMBLE = 9;
  localparam int NUM_GAPS = 8;

  typedef enum logic [2:0] {
    CMD_NOP = 3'h0,
    CMD_ACT = 3'h1,
    CMD_RD = 3'h2,
    CMD_WR = 3'h3,
    CMD_WRA = 3'h4,
    CMD_PRE = 3'h5,
    CMD_MRS = 3'h6,
    CMD_MPR_EXIT = 3'h7
  } cmd_t;

  typedef enum logic [1:0] {
    WS_IDLE = 2'h0,
    WS_PRE = 2'h1,
    WS_BURST = 2'h3
  } wr_state_t;

endpackage
